// File: hw/fps_pkg.sv
// Purpose: constants for the flash status polling controller
// Assumes: 8-bit status word on the low data lines, 200 MHz clock
// Notes:   read and write pulse widths are in clock cycles
package fps_pkg;
  // status word bit positions
  localparam int unsigned POLL_BIT   = 7;
  localparam int unsigned TOGGLE_BIT = 6;
  localparam int unsigned ERROR_BIT  = 5;
  localparam int unsigned TIMER_BIT  = 3;
  localparam int unsigned ALT_BIT    = 2;
  // bus timing: 70 ns cycle, 5 ns clock
  localparam int unsigned CLK_NS     = 5;
  localparam int unsigned T_RC_NS    = 70;
  localparam int unsigned T_WC_NS    = 70;
  localparam logic [4:0]  RD_CYC     = 5'((T_RC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0]  WR_CYC     = 5'((T_WC_NS + CLK_NS - 1) / CLK_NS);
  // software register offsets
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_ADDR   = 4'h1;
  localparam logic [3:0]  REG_DATA   = 4'h2;
  localparam logic [3:0]  REG_STAT   = 4'h3;
  localparam logic [3:0]  REG_RDATA  = 4'h4;
  localparam logic [3:0]  REG_LIMIT  = 4'h5;
  // control word command codes
  localparam logic [2:0]  CMD_READ   = 3'h1;
  localparam logic [2:0]  CMD_WRITE  = 3'h2;
  localparam logic [2:0]  CMD_POLLPG = 3'h3;
  localparam logic [2:0]  CMD_TOGGLE = 3'h4;
  localparam logic [2:0]  CMD_TIMER  = 3'h5;
  localparam logic [15:0] LIMIT_RST  = 16'hffff;
  // result codes in status register
  localparam logic [1:0]  RES_OK     = 2'h0;
  localparam logic [1:0]  RES_FAIL   = 2'h1;
  localparam logic [1:0]  RES_TOUT   = 2'h2;
  localparam logic [1:0]  RES_SUSP   = 2'h3;
  localparam logic [7:0]  RESET_CMD  = 8'hf0;
  typedef enum logic [2:0] {
    FPS_IDLE, FPS_BUS, FPS_EVAL, FPS_DONE
  } fps_state_t;
endpackage : fps_pkg

// File: hw/fps_bus_cycle.sv
// Purpose: one asynchronous flash bus read or write cycle
// Assumes: data in is synchronous to the clock
// Notes:   read data captured just before output enable rises
`timescale 1ns/1ps
`default_nettype none
module fps_bus_cycle (
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_start,
  input  wire logic        i_write,
  input  wire logic [19:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic [15:0] i_dq_in,
  output logic             o_done,
  output logic [15:0]      o_rdata,
  output logic [19:0]      o_addr,
  output logic [15:0]      o_dq_out,
  output logic             o_dq_oe,
  output logic             o_ce_n,
  output logic             o_oe_n,
  output logic             o_we_n
);
  logic [4:0]  cnt_r,   cnt_nxt;
  logic        act_r,   act_nxt;
  logic        wr_r,    wr_nxt;
  logic [19:0] addr_r,  addr_nxt;
  logic [15:0] wd_r,    wd_nxt;
  logic [15:0] rd_r,    rd_nxt;
  logic        done_r,  done_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    act_nxt  = act_r;
    wr_nxt   = wr_r;
    addr_nxt = addr_r;
    wd_nxt   = wd_r;
    rd_nxt   = rd_r;
    done_nxt = 1'b0;
    if (!act_r && i_start) begin
      act_nxt  = 1'b1;
      wr_nxt   = i_write;
      addr_nxt = i_addr;
      wd_nxt   = i_wdata;
      cnt_nxt  = i_write ? fps_pkg::WR_CYC : fps_pkg::RD_CYC;
    end else if (act_r) begin
      if (cnt_r == 5'h1) begin
        // strobe rises now: one completed cycle per pulse
        act_nxt  = 1'b0;
        done_nxt = 1'b1;
        if (!wr_r) begin
          rd_nxt = i_dq_in;
        end
      end
      cnt_nxt = cnt_r - 5'h1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cnt_r  <= 5'h0;
      act_r  <= 1'b0;
      wr_r   <= 1'b0;
      addr_r <= 20'h0;
      wd_r   <= 16'h0;
      rd_r   <= 16'h0;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      act_r  <= act_nxt;
      wr_r   <= wr_nxt;
      addr_r <= addr_nxt;
      wd_r   <= wd_nxt;
      rd_r   <= rd_nxt;
      done_r <= done_nxt;
    end
  end

  assign o_done   = done_r;
  assign o_rdata  = rd_r;
  assign o_addr   = addr_r;
  assign o_dq_out = wd_r;
  assign o_dq_oe  = act_r & wr_r;
  assign o_ce_n   = ~act_r;
  assign o_oe_n   = ~(act_r & ~wr_r);
  // write strobe released one cycle early so data holds past its edge
  assign o_we_n   = ~(act_r & wr_r & (cnt_r != 5'h1));
endmodule : fps_bus_cycle
`default_nettype wire

// File: hw/fps_ctrl.sv
// Purpose: host controller that polls a flash status word
// Assumes: device registers reached only through its bus pins
// Notes:   software orders a read, write or a polling run
//
// Operation
// - host polls at programmed address or inside erasing block.
// - after error, host issues read/reset before other commands; this controller leaves it to software.
// - blocks may be appended only while erase-timer bit is zero.
// - host ignores status bits undefined for the operation.
`timescale 1ns/1ps
`default_nettype none
module fps_ctrl (
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  input  wire logic [15:0] i_dq_in,
  output logic [15:0]      o_dq_out,
  output logic             o_dq_oe,
  output logic [19:0]      o_fl_addr,
  output logic             o_ce_n,
  output logic             o_oe_n,
  output logic             o_we_n,
  input  wire logic        i_ready_busy_n
);
  fps_pkg::fps_state_t st_r, st_nxt;
  logic [2:0]  cmd_r,   cmd_nxt;
  logic [19:0] fa_r,    fa_nxt;
  logic [15:0] fd_r,    fd_nxt;
  logic [15:0] lim_r,   lim_nxt;
  logic [15:0] polls_r, polls_nxt;
  logic [15:0] last_r,  last_nxt;
  logic [15:0] rdv_r,   rdv_nxt;
  logic        first_r, first_nxt;
  logic        echk_r,  echk_nxt;
  logic        busy_r,  busy_nxt;
  logic        done_r,  done_nxt;
  logic [1:0]  res_r,   res_nxt;
  logic        tmr_r,   tmr_nxt;
  logic [31:0] rd_r,    rd_nxt;
  logic        cyc_start;
  logic        cyc_write;
  logic        cyc_done;
  logic [15:0] cyc_rdata;

  // bit differs between two successive status reads
  function automatic logic flipped(input logic [15:0] a,
                                   input logic [15:0] b,
                                   input int unsigned pos);
    flipped = a[pos] ^ b[pos];
  endfunction

  fps_bus_cycle u_cyc (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_start   (cyc_start),
    .i_write   (cyc_write),
    .i_addr    (fa_r),
    .i_wdata   (fd_r),
    .i_dq_in   (i_dq_in),
    .o_done    (cyc_done),
    .o_rdata   (cyc_rdata),
    .o_addr    (o_fl_addr),
    .o_dq_out  (o_dq_out),
    .o_dq_oe   (o_dq_oe),
    .o_ce_n    (o_ce_n),
    .o_oe_n    (o_oe_n),
    .o_we_n    (o_we_n)
  );

  assign cyc_start = (st_r == fps_pkg::FPS_BUS);
  assign cyc_write = (cmd_r == fps_pkg::CMD_WRITE);

  always_comb begin
    st_nxt    = st_r;
    cmd_nxt   = cmd_r;
    fa_nxt    = fa_r;
    fd_nxt    = fd_r;
    lim_nxt   = lim_r;
    polls_nxt = polls_r;
    last_nxt  = last_r;
    rdv_nxt   = rdv_r;
    first_nxt = first_r;
    echk_nxt  = echk_r;
    busy_nxt  = busy_r;
    done_nxt  = done_r;
    res_nxt   = res_r;
    tmr_nxt   = tmr_r;
    rd_nxt    = 32'h0;
    if (i_wr && !busy_r) begin
      case (i_addr)
        fps_pkg::REG_ADDR:  fa_nxt  = i_wdata[19:0];
        fps_pkg::REG_DATA:  fd_nxt  = i_wdata[15:0];
        fps_pkg::REG_LIMIT: lim_nxt = i_wdata[15:0];
        fps_pkg::REG_CTRL: begin
          cmd_nxt   = i_wdata[2:0];
          busy_nxt  = 1'b1;
          done_nxt  = 1'b0;
          first_nxt = 1'b1;
          echk_nxt  = 1'b0;
          polls_nxt = 16'h0;
          st_nxt    = fps_pkg::FPS_BUS;
        end
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        fps_pkg::REG_ADDR:  rd_nxt = {12'h0, fa_r};
        fps_pkg::REG_DATA:  rd_nxt = {16'h0, fd_r};
        fps_pkg::REG_LIMIT: rd_nxt = {16'h0, lim_r};
        fps_pkg::REG_RDATA: rd_nxt = {16'h0, rdv_r};
        fps_pkg::REG_STAT:  rd_nxt = {polls_r, 10'h0, tmr_r,
                                      i_ready_busy_n, res_r,
                                      done_r, busy_r};
        default:            rd_nxt = 32'h0;
      endcase
    end
    case (st_r)
      fps_pkg::FPS_IDLE: ;
      fps_pkg::FPS_BUS:  st_nxt = fps_pkg::FPS_EVAL;
      fps_pkg::FPS_EVAL: begin
        if (cyc_done) begin
          rdv_nxt   = cyc_rdata;
          last_nxt  = cyc_rdata;
          first_nxt = 1'b0;
          polls_nxt = polls_r + 16'h1;
          st_nxt    = fps_pkg::FPS_BUS;
          case (cmd_r)
            fps_pkg::CMD_READ, fps_pkg::CMD_WRITE: begin
              res_nxt = fps_pkg::RES_OK;
              st_nxt  = fps_pkg::FPS_DONE;
            end
            fps_pkg::CMD_POLLPG: begin
              // programmed bit on the polling line means finished
              if (cyc_rdata[fps_pkg::POLL_BIT] == fd_r[fps_pkg::POLL_BIT]) begin
                res_nxt = fps_pkg::RES_OK;
                st_nxt  = fps_pkg::FPS_DONE;
              end else if (echk_r) begin
                res_nxt = fps_pkg::RES_FAIL;
                st_nxt  = fps_pkg::FPS_DONE;
              end else if (cyc_rdata[fps_pkg::ERROR_BIT]) begin
                // recheck once: completion may race the error bit
                echk_nxt = 1'b1;
              end
            end
            fps_pkg::CMD_TOGGLE: begin
              // toggling proves a status word, not array data
              if (!first_r) begin
                if (!flipped(cyc_rdata, last_r, fps_pkg::TOGGLE_BIT)) begin
                  // stopped: done, or erase actually suspended
                  res_nxt = (cyc_rdata[fps_pkg::POLL_BIT] &&
                             flipped(cyc_rdata, last_r, fps_pkg::ALT_BIT))
                            ? fps_pkg::RES_SUSP : fps_pkg::RES_OK;
                  st_nxt  = fps_pkg::FPS_DONE;
                end else if (echk_r) begin
                  // still toggling after the error bit: real failure
                  res_nxt = fps_pkg::RES_FAIL;
                  st_nxt  = fps_pkg::FPS_DONE;
                end else if (cyc_rdata[fps_pkg::ERROR_BIT]) begin
                  // only error and toggle bits trusted here
                  // array data can mimic one toggle at the end: reread
                  echk_nxt = 1'b1;
                end
              end
            end
            fps_pkg::CMD_TIMER: begin
              // report timer bit; software appends blocks while zero
              tmr_nxt = cyc_rdata[fps_pkg::TIMER_BIT];
              res_nxt = fps_pkg::RES_OK;
              st_nxt  = fps_pkg::FPS_DONE;
            end
            default: st_nxt = fps_pkg::FPS_DONE;
          endcase
          if (st_nxt == fps_pkg::FPS_BUS && polls_nxt >= lim_r) begin
            res_nxt = fps_pkg::RES_TOUT;
            st_nxt  = fps_pkg::FPS_DONE;
          end
        end
      end
      fps_pkg::FPS_DONE: begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        st_nxt   = fps_pkg::FPS_IDLE;
      end
      default: st_nxt = fps_pkg::FPS_IDLE;
    endcase
  end
  // failure leaves recovery to software: it must write the reset
  // command before anything else, and a failed program of a zero
  // bit is reported as fail, never retried

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_r    <= fps_pkg::FPS_IDLE;
      cmd_r   <= 3'h0;
      fa_r    <= 20'h0;
      fd_r    <= 16'h0;
      lim_r   <= fps_pkg::LIMIT_RST;
      polls_r <= 16'h0;
      last_r  <= 16'h0;
      rdv_r   <= 16'h0;
      first_r <= 1'b0;
      echk_r  <= 1'b0;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
      res_r   <= fps_pkg::RES_OK;
      tmr_r   <= 1'b0;
      rd_r    <= 32'h0;
    end else begin
      st_r    <= st_nxt;
      cmd_r   <= cmd_nxt;
      fa_r    <= fa_nxt;
      fd_r    <= fd_nxt;
      lim_r   <= lim_nxt;
      polls_r <= polls_nxt;
      last_r  <= last_nxt;
      rdv_r   <= rdv_nxt;
      first_r <= first_nxt;
      echk_r  <= echk_nxt;
      busy_r  <= busy_nxt;
      done_r  <= done_nxt;
      res_r   <= res_nxt;
      tmr_r   <= tmr_nxt;
      rd_r    <= rd_nxt;
    end
  end

  assign o_rdata = rd_r;
endmodule : fps_ctrl
`default_nettype wire

// File: test/fps_checker.sv
// Purpose: pin level checks on the flash polling controller
// Assumes: one clock, sync active-high reset
// Notes:   bound to every fps_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module fps_checker (
  input wire logic        i_sys_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_dq_oe,
  input wire logic [19:0] o_fl_addr,
  input wire logic        o_ce_n,
  input wire logic        o_oe_n,
  input wire logic        o_we_n
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data seen outside its reply cycle");
  AST_OE_NEEDS_CE: assert property (!o_oe_n |-> !o_ce_n && o_we_n)
    else $error("output enable without chip enable");
  AST_NO_FIGHT: assert property (!o_oe_n |-> !o_dq_oe)
    else $error("data driven while device outputs");
  AST_RD_LEN: assert property ($fell(o_oe_n) |->
    !o_oe_n [*7] ##1 !o_oe_n [*7] ##1 o_oe_n)
    else $error("read strobe not 14 cycles");
  AST_WR_LEN: assert property ($fell(o_we_n) |->
    !o_we_n [*7] ##1 !o_we_n [*6] ##1 o_we_n)
    else $error("write strobe not 13 cycles");
  AST_WE_DRIVE: assert property (!o_we_n |-> !o_ce_n && o_dq_oe)
    else $error("write strobe without chip enable or data");
  AST_ADDR_HOLD: assert property (!o_ce_n && !$past(o_ce_n) |->
    $stable(o_fl_addr))
    else $error("address moved inside a bus cycle");
  AST_GAP: assert property ($rose(o_ce_n) |=> o_ce_n)
    else $error("no idle gap between bus cycles");
  AST_RST_IDLE: assert property ($past(i_sys_rst) |->
    o_ce_n && o_oe_n && o_we_n && !o_dq_oe)
    else $error("strobes active right after reset");
endmodule // fps_checker
bind fps_ctrl fps_checker chk_u (.i_sys_clk(i_sys_clk),
  .i_sys_rst(i_sys_rst), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_dq_oe(o_dq_oe), .o_fl_addr(o_fl_addr), .o_ce_n(o_ce_n),
  .o_oe_n(o_oe_n), .o_we_n(o_we_n));
`default_nettype wire

// File: test/fps_flash_model.sv
// Purpose: behavioural flash status word at the far side
// Assumes: one word of array, every address inside the erasing block
// Notes:   mode 0 idle, 1 program, 2 erase, 3 erase then suspend
`timescale 1ns/1ps
`default_nettype none
module fps_flash_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_go,
  input  wire logic [1:0]  i_mode,
  input  wire logic [15:0] i_n,
  input  wire logic        i_fail,
  input  wire logic [15:0] i_pdata,
  input  wire logic [19:0] i_addr,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  output logic [15:0]      o_dq,
  output logic             o_rb_n
);
  logic [1:0] mode; logic [15:0] n, cnt, mem, pd, last, wd, wrd;
  logic busy, fail, tg, al, oe_q, we_q, susp, err, drv;
  logic [19:0] wa;
  assign susp = mode == 2'h3 && cnt >= n;
  assign err = fail && cnt >= n;
  assign wrd = busy ? {8'h0, (mode == 2'h1) ? ~pd[7] : susp,
    tg, err, 1'b0, cnt != 16'h0, al, 2'h0} : mem;
  assign drv = !i_ce_n && !i_oe_n;
  // released bus shows the inverse, not a stale copy
  assign o_dq = drv ? wrd : ~last;
  assign o_rb_n = !busy || susp;
  always @(posedge i_sys_clk) begin
    oe_q <= i_oe_n;
    we_q <= i_we_n;
    if (drv) last <= wrd;
    if (i_go) begin
      mode <= i_mode; n <= i_n; fail <= i_fail; pd <= i_pdata;
      cnt <= 16'h0; busy <= i_mode != 2'h0; tg <= 1'b0; al <= 1'b0;
      if (i_mode == 2'h0) mem <= i_pdata;
    end else begin
      if (i_oe_n && !oe_q && busy) begin
        cnt <= cnt + 16'h1;
        if (!susp) tg <= ~tg;
        if (mode != 2'h1) al <= ~al;
        if (cnt + 16'h1 == n && !fail && mode != 2'h3) begin
          busy <= 1'b0;
          mem <= (mode == 2'h1) ? mem & pd : 16'hffff;
        end
      end
      if (i_we_n && !we_q) begin
        wa <= i_addr; wd <= i_dq;
        if (i_dq[7:0] == 8'hf0) busy <= 1'b0;
      end
    end
  end
endmodule // fps_flash_model
`default_nettype wire

// File: test/test_fps_ctrl.sv
// Purpose: self-checking bench for the flash polling controller
// Assumes: flash model answers on the pins, checker bound by module
// Notes:   results compared with values worked out from the table
`timescale 1ns/1ps
`default_nettype none
module test_fps_ctrl;
  logic clk, rst, wr, rd, go, fl, rb_n, d_oe, ce_n, oe_n, we_n;
  logic [3:0] a; logic [31:0] wd, rdt, s; logic [1:0] md;
  logic [15:0] nn, pd, d_out, f_dq, dq, p, em; logic [19:0] fa, ad;
  int miscompares = 0, n_compared = 0;
  assign dq = d_oe ? d_out : f_dq;
  fps_ctrl dut_u (.i_sys_clk(clk), .i_sys_rst(rst), .i_addr(a),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdt), .i_dq_in(dq),
    .o_dq_out(d_out), .o_dq_oe(d_oe), .o_fl_addr(fa), .o_ce_n(ce_n),
    .o_oe_n(oe_n), .o_we_n(we_n), .i_ready_busy_n(rb_n));
  fps_flash_model fl_u (.i_sys_clk(clk), .i_go(go), .i_mode(md),
    .i_n(nn), .i_fail(fl), .i_pdata(pd), .i_addr(fa), .i_dq(dq),
    .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .o_dq(f_dq),
    .o_rb_n(rb_n));
  initial begin clk = 0; forever #2.5 clk = ~clk; end
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wreg(input logic [3:0] ad4, input logic [31:0] v);
    @(posedge clk) begin wr <= 1; a <= ad4; wd <= v; end
    @(posedge clk) wr <= 0;
  endtask
  task rreg(input logic [3:0] ad4, output logic [31:0] v);
    @(posedge clk) begin rd <= 1; a <= ad4; end
    @(posedge clk) rd <= 0;
    #1 v = rdt;
  endtask
  task start(input logic [1:0] m, input int k, input logic f,
             input logic [15:0] d);
    @(posedge clk) begin go <= 1; md <= m; nn <= 16'(k); fl <= f;
      pd <= d; end
    @(posedge clk) go <= 0;
  endtask
  task cmd(input logic [2:0] c);
    int k;
    wreg(fps_pkg::REG_CTRL, {29'h0, c});
    s = 32'h1;
    for (k = 0; k < 3000 && s[0] !== 1'b0; k++) rreg(fps_pkg::REG_STAT, s);
    if (k == 3000) begin miscompares++; close_out(); end
    chk("done", {31'h0, s[1]}, 32'h1);
  endtask
  task flwrite(input logic [15:0] d);
    wreg(fps_pkg::REG_DATA, {16'h0, d});
    cmd(fps_pkg::CMD_WRITE);
  endtask
  // result code after a polling run against a model mode
  task poll(input logic [2:0] c, input logic [1:0] m, input int k,
            input logic f, input logic [1:0] e, input string nm);
    wreg(fps_pkg::REG_DATA, 32'hffff);
    start(m, k, f, 16'hffff);
    cmd(c);
    chk("result", {30'h0, s[3:2]}, {30'h0, e});
    if (e == fps_pkg::RES_TOUT)
      chk("reads", {16'h0, s[31:16]}, 32'h4);
    if (e != fps_pkg::RES_OK) flwrite(fps_pkg::RESET_CMD);
    $display("test %s done", nm);
  endtask
  initial begin
    rst = 1; wr = 0; rd = 0; go = 0; a = 0; wd = 0; md = 0; nn = 0;
    fl = 0; pd = 0;
    void'($urandom(32'h8a71));
    repeat (12) @(posedge clk);
    rst <= 0;
    rreg(fps_pkg::REG_LIMIT, s);
    chk("limit", s, 32'hffff);
    rreg(4'h7, s);
    chk("unmapped", s, 32'h0);
    wreg(fps_pkg::REG_LIMIT, 32'h40);
    ad = 20'($urandom); p = 16'($urandom);
    wreg(fps_pkg::REG_ADDR, {12'h0, ad});
    start(2'h0, 0, 0, 16'($urandom));
    flwrite(p);
    chk("waddr", {12'h0, fl_u.wa}, {12'h0, ad});
    chk("wdata", {16'h0, fl_u.wd}, {16'h0, p});
    start(2'h0, 0, 0, p);
    cmd(fps_pkg::CMD_READ);
    rreg(fps_pkg::REG_RDATA, s);
    chk("array read", s, {16'h0, p});
    $display("test write read done");
    em = p;
    for (int i = 0; i < 2; i++) begin
      p = 16'($urandom);
      // a zero polling bit cannot be set back, so polling would never see it match
      p[7] = p[7] & em[7];
      em = em & p;
      wreg(fps_pkg::REG_DATA, {16'h0, p});
      start(2'h1, 3, 0, p);
      cmd(fps_pkg::CMD_POLLPG);
      chk("program", {30'h0, s[3:2]}, 32'h0);
      cmd(fps_pkg::CMD_READ);
      rreg(fps_pkg::REG_RDATA, s);
      chk("programmed", s, {16'h0, em});
    end
    $display("test program done");
    poll(fps_pkg::CMD_POLLPG, 2'h1, 2, 1, fps_pkg::RES_FAIL, "pgfail");
    poll(fps_pkg::CMD_TOGGLE, 2'h2, 3, 0, fps_pkg::RES_OK, "erase");
    poll(fps_pkg::CMD_TOGGLE, 2'h2, 2, 1, fps_pkg::RES_FAIL, "erfail");
    poll(fps_pkg::CMD_TOGGLE, 2'h3, 3, 0, fps_pkg::RES_SUSP, "susp");
    wreg(fps_pkg::REG_LIMIT, 32'h4);
    poll(fps_pkg::CMD_TOGGLE, 2'h2, 900, 0, fps_pkg::RES_TOUT, "tout");
    wreg(fps_pkg::REG_LIMIT, 32'h40);
    start(2'h2, 900, 0, 16'hffff);
    cmd(fps_pkg::CMD_TIMER);
    chk("timer before", {30'h0, s[5:4]}, 32'h0);
    cmd(fps_pkg::CMD_TIMER);
    chk("timer after", {30'h0, s[5:4]}, 32'h2);
    flwrite(fps_pkg::RESET_CMD);
    $display("test timer done");
    close_out();
  end
endmodule // test_fps_ctrl
`default_nettype wire
